//--- logic/cfg_regs.svh
// Purpose: Constants of the test-port configuration engine
// Assumes: One instruction register of IR_W bits, one shared data register
// Notes:   Instruction codes are the block's own encoding
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH
`define IR_W 4
`define DR_W 32
`define IR_CAPT 4'h1
`define IR_NV_OFF 4'h2
`define IR_NV_BG 4'h3
`define IR_SRAM_WR 4'h4
`define IR_REFRESH 4'h5
`define IR_LIVE_UPD 4'h6
`define IR_RD_SRAM 4'h7
`define IR_RD_NV 4'h8
`define IR_ERASE 4'h9
`define IR_SECURE 4'hA
`define IR_PIN_SET 4'hB
`define IR_ADDR 4'hC
`define IR_EXIT 4'hD
`define IR_BYPASS 4'hF
`define PIN_MODE_RST 2'h3
`endif

//--- logic/cfg_pkg.sv
// Purpose: Types shared by the configuration engine and its pin cells
// Assumes: Constants come from cfg_regs.svh
// Notes:   State and mode codes follow declaration order; none are written out
package cfg_pkg;
   typedef enum logic [3:0] {
      T_TLR, T_RTI, T_SDR, T_CDR, T_SHDR, T_E1DR, T_PDR, T_E2DR, T_UDR,
      T_SIR, T_CIR, T_SHIR, T_E1IR, T_PIR, T_E2IR, T_UIR
   } tap_e;
   typedef enum logic {C_LOAD, C_IDLE} core_e;
   typedef enum logic [1:0] {PM_HOLD, PM_LOW, PM_HIGH, PM_TRI} pin_mode_e;
endpackage : cfg_pkg

//--- logic/pin_leave_alone.sv
// Purpose: One I/O pin cell: user drive, or a chosen state while offline
// Assumes: Mode and offline flag come from the core clock domain
// Notes:   Hold keeps the last value the user logic drove
`timescale 1ns/1ns
`include "cfg_regs.svh"
module pin_leave_alone
   import cfg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // User side
   input wire logic i_user_o,
   input wire logic i_user_oe,
   // Control
   input wire logic i_off,
   input wire logic [1:0] i_mode,
   // Pin
   output logic o_pin,
   output logic o_oe
);
   logic hold_o_q, hold_oe_q, hold_o_d, hold_oe_d, pin_d, oe_d;

   always_comb begin
      hold_o_d = i_off ? hold_o_q : i_user_o;
      hold_oe_d = i_off ? hold_oe_q : i_user_oe;
      pin_d = i_user_o;
      oe_d = i_user_oe;
      if (i_off) begin
         case (i_mode)
            PM_HIGH: begin pin_d = 1'b1; oe_d = 1'b1; end
            PM_LOW: begin pin_d = 1'b0; oe_d = 1'b1; end
            PM_TRI: begin pin_d = 1'b0; oe_d = 1'b0; end
            default: begin pin_d = hold_o_q; oe_d = hold_oe_q; end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_o_q <= 1'b0;
         hold_oe_q <= 1'b0;
         o_pin <= 1'b0;
         o_oe <= 1'b0;
      end else begin
         hold_o_q <= hold_o_d;
         hold_oe_q <= hold_oe_d;
         o_pin <= pin_d;
         o_oe <= oe_d;
      end
   end

   chk_pin_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_off && $past(i_off) && i_mode == PM_HOLD |=> o_pin == hold_o_q && o_oe == hold_oe_q)
      else $error("held pin moved");
   chk_pin_tri: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_off && i_mode == PM_TRI |=> !o_oe)
      else $error("tristated pin still driven");
endmodule : pin_leave_alone

//--- logic/cfg_engine.sv
// Purpose: Test-port configuration and nonvolatile programming engine
// Assumes: Host waits for the busy bit to drop before each new command
// Notes:   Test logic runs on I_TCK, memories and pins on I_CLK
`timescale 1ns/1ns
`include "cfg_regs.svh"
module cfg_engine
   import cfg_pkg::*;
#(
   parameter int NPIN = 8,
   parameter int WORDS = 16
) (
   // Core clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // Test port
   input wire logic I_TCK,
   input wire logic I_TMS,
   input wire logic I_TDI,
   output logic O_TDO,
   output logic O_TDO_OE,
   // User logic
   input wire logic [NPIN-1:0] I_USER_O,
   input wire logic [NPIN-1:0] I_USER_OE,
   output logic O_USER_EN,
   output logic [WORDS*`DR_W-1:0] O_SRAM_CFG,
   output logic O_SECURE,
   // Pins
   output logic [NPIN-1:0] O_PIO_O,
   output logic [NPIN-1:0] O_PIO_OE
);
   localparam int AW = $clog2(WORDS);
   localparam logic [AW-1:0] LAST = AW'(WORDS - 1);

   if (WORDS < 2 || (1 << AW) != WORDS || NPIN < 1 || NPIN > `DR_W / 2) begin : g_bad
      $error("cfg_engine: WORDS must be a power of two, NPIN 1..16");
   end

   // ****************************************
   // Test clock domain
   // ****************************************
   tap_e tap_q, tap_d;
   logic [`IR_W-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d, jc_q, jc_d;
   logic [`DR_W-1:0] dr_q, dr_d, jd_q, jd_d, rd_q, rd_d;
   logic req_q, req_d, ack1_q, ack2_q, ack_q, ack_d, busy, rd_inst;

   assign busy = req_q != ack2_q;
   assign rd_inst = ir_q == `IR_RD_SRAM || ir_q == `IR_RD_NV;

   always_comb begin
      case (tap_q)
         T_TLR: tap_d = I_TMS ? T_TLR : T_RTI;
         T_RTI: tap_d = I_TMS ? T_SDR : T_RTI;
         T_SDR: tap_d = I_TMS ? T_SIR : T_CDR;
         T_CDR: tap_d = I_TMS ? T_E1DR : T_SHDR;
         T_SHDR: tap_d = I_TMS ? T_E1DR : T_SHDR;
         T_E1DR: tap_d = I_TMS ? T_UDR : T_PDR;
         T_PDR: tap_d = I_TMS ? T_E2DR : T_PDR;
         T_E2DR: tap_d = I_TMS ? T_UDR : T_SHDR;
         T_UDR: tap_d = I_TMS ? T_SDR : T_RTI;
         T_SIR: tap_d = I_TMS ? T_TLR : T_CIR;
         T_CIR: tap_d = I_TMS ? T_E1IR : T_SHIR;
         T_SHIR: tap_d = I_TMS ? T_E1IR : T_SHIR;
         T_E1IR: tap_d = I_TMS ? T_UIR : T_PIR;
         T_PIR: tap_d = I_TMS ? T_E2IR : T_PIR;
         T_E2IR: tap_d = I_TMS ? T_UIR : T_SHIR;
         T_UIR: tap_d = I_TMS ? T_SDR : T_RTI;
         default: tap_d = T_TLR;
      endcase
   end

   always_comb begin
      ir_d = ir_q;
      ir_sh_d = ir_sh_q;
      dr_d = dr_q;
      req_d = req_q;
      jc_d = jc_q;
      jd_d = jd_q;
      case (tap_q)
         T_TLR: ir_d = `IR_BYPASS;
         T_CIR: ir_sh_d = `IR_CAPT;
         T_SHIR: ir_sh_d = {I_TDI, ir_sh_q[`IR_W-1:1]};
         T_UIR: ir_d = ir_sh_q;
         // Read data is stable here: the core only changes it inside a handshake
         T_CDR: dr_d = rd_inst ? rd_q : `DR_W'(busy);
         T_SHDR: dr_d = (ir_q == `IR_BYPASS) ? `DR_W'(I_TDI) : {I_TDI, dr_q[`DR_W-1:1]};
         T_UDR: begin
            // A command while busy is dropped; the host sees busy on capture unless a read code is loaded
            if (ir_q != `IR_BYPASS && !busy) begin
               req_d = ~req_q;
               jc_d = ir_q;
               jd_d = dr_q;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge I_TCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tap_q <= T_TLR;
         ir_q <= `IR_BYPASS;
         {ir_sh_q, dr_q, jc_q, jd_q} <= '0;
         {req_q, ack1_q, ack2_q} <= 3'h0;
      end else begin
         tap_q <= tap_d;
         ir_q <= ir_d;
         {ir_sh_q, dr_q, jc_q, jd_q} <= {ir_sh_d, dr_d, jc_d, jd_d};
         {req_q, ack1_q, ack2_q} <= {req_d, ack_q, ack1_q};
      end
   end
   // Output changes on the falling edge so the host samples on its rising edge
   always_ff @(negedge I_TCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_TDO <= 1'b0;
         O_TDO_OE <= 1'b0;
      end else begin
         O_TDO <= (tap_q == T_SHIR) ? ir_sh_q[0] : dr_q[0];
         O_TDO_OE <= tap_q == T_SHIR || tap_q == T_SHDR;
      end
   end

   chk_busy_refuse: assert property (@(posedge I_TCK) disable iff (!I_RST_N)
      tap_q == T_UDR && busy |=> req_q == $past(req_q) && jd_q == $past(jd_q))
      else $error("command taken while busy");
   // ****************************************
   // Core clock domain
   // ****************************************
   core_e st_q, st_d;
   logic [AW-1:0] ptr_q, ptr_d, addr_q, addr_d;
   logic [WORDS-1:0][`DR_W-1:0] nv_q, nv_d, sram_q, sram_d;
   logic [NPIN-1:0][1:0] mode_q, mode_d, eff_mode;
   logic sec_q, sec_d, off_q, off_d, live_q, live_d, go_q, go_d, ldack_q, ldack_d;
   logic rq1_q, rq2_q, rq3_q, pulse, pin_off, take;

   assign pulse = rq2_q ^ rq3_q;
   assign take = st_q == C_IDLE && (go_q || pulse);

   always_comb begin
      st_d = st_q;
      ptr_d = ptr_q;
      addr_d = addr_q;
      nv_d = nv_q;
      sram_d = sram_q;
      sec_d = sec_q;
      off_d = off_q;
      live_d = live_q;
      rd_d = rd_q;
      ack_d = ack_q;
      mode_d = mode_q;
      ldack_d = ldack_q;
      go_d = go_q || pulse;
      case (st_q)
         C_LOAD: begin
            sram_d[ptr_q] = nv_q[ptr_q];
            ptr_d = ptr_q + 1'b1;
            if (ptr_q == LAST) begin
               st_d = C_IDLE;
               live_d = 1'b0;
               ldack_d = 1'b0;
               if (ldack_q) ack_d = ~ack_q;
            end
         end
         C_IDLE: begin
            if (go_q || pulse) begin
               go_d = 1'b0;
               ack_d = ~ack_q;
               case (jc_q)
                  `IR_NV_OFF: begin
                     off_d = 1'b1;
                     nv_d[addr_q] = jd_q;
                     addr_d = addr_q + 1'b1;
                  end
                  `IR_NV_BG: begin
                     nv_d[addr_q] = jd_q;
                     addr_d = addr_q + 1'b1;
                  end
                  `IR_SRAM_WR: begin
                     off_d = 1'b1;
                     sram_d[addr_q] = jd_q;
                     addr_d = addr_q + 1'b1;
                  end
                  `IR_REFRESH, `IR_LIVE_UPD: begin
                     st_d = C_LOAD;
                     ptr_d = '0;
                     ack_d = ack_q;
                     ldack_d = 1'b1;
                     live_d = jc_q == `IR_LIVE_UPD;
                  end
                  `IR_RD_SRAM: begin
                     rd_d = sec_q ? '0 : sram_q[addr_q];
                     addr_d = addr_q + 1'b1;
                  end
                  `IR_RD_NV: begin
                     rd_d = sec_q ? '0 : nv_q[addr_q];
                     addr_d = addr_q + 1'b1;
                  end
                  `IR_ERASE: begin
                     nv_d = '0;
                     sram_d = '0;
                     sec_d = 1'b0;
                     addr_d = '0;
                  end
                  `IR_SECURE: sec_d = 1'b1;
                  `IR_PIN_SET: mode_d = jd_q[2*NPIN-1:0];
                  `IR_ADDR: addr_d = jd_q[AW-1:0];
                  `IR_EXIT: off_d = 1'b0;
                  default: ;
               endcase
            end
         end
         default: st_d = C_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_q <= C_LOAD;
         {ptr_q, addr_q, nv_q, sram_q, rd_q} <= '0;
         {sec_q, off_q, live_q, ack_q, ldack_q, go_q} <= 6'h00;
         mode_q <= {NPIN{`PIN_MODE_RST}};
         {rq1_q, rq2_q, rq3_q} <= 3'h0;
      end else begin
         st_q <= st_d;
         {ptr_q, addr_q, nv_q, sram_q, rd_q} <= {ptr_d, addr_d, nv_d, sram_d, rd_d};
         {sec_q, off_q, live_q, ack_q, ldack_q, go_q} <= {sec_d, off_d, live_d, ack_d, ldack_d, go_d};
         mode_q <= mode_d;
         {rq1_q, rq2_q, rq3_q} <= {req_q, rq1_q, rq2_q};
      end
   end

   // ****************************************
   // Pins and user side
   // ****************************************
   assign pin_off = off_q || st_q == C_LOAD;
   assign eff_mode = live_q ? {NPIN{2'(PM_HOLD)}} : mode_q;
   assign O_USER_EN = st_q == C_IDLE && !off_q;
   assign O_SRAM_CFG = sram_q;
   assign O_SECURE = sec_q;

   for (genvar p = 0; p < NPIN; p++) begin : g_pin
      pin_leave_alone u_pin (
         .i_clk(I_CLK),
         .i_rst_n(I_RST_N),
         .i_user_o(I_USER_O[p]),
         .i_user_oe(I_USER_OE[p]),
         .i_off(pin_off),
         .i_mode(eff_mode[p]),
         .o_pin(O_PIO_O[p]),
         .o_oe(O_PIO_OE[p])
      );
   end
   chk_load_done: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      st_q == C_LOAD && ptr_q == LAST |=> st_q == C_IDLE && sram_q[LAST] == nv_q[LAST])
      else $error("load did not finish on last word");
   chk_refresh_go: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && (jc_q == `IR_REFRESH) |=> st_q == C_LOAD && ptr_q == '0)
      else $error("refresh did not start a reload");
   chk_sram_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && jc_q == `IR_SRAM_WR |=> sram_q[$past(addr_q)] == $past(jd_q))
      else $error("direct SRAM write lost");
   chk_offline_user: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && jc_q == `IR_NV_OFF |=> !O_USER_EN [*2])
      else $error("user logic live while offline");
   chk_bg_running: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && jc_q == `IR_NV_BG && O_USER_EN |=> O_USER_EN)
      else $error("background write stopped user logic");
   chk_bg_sram: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && jc_q == `IR_NV_BG |=> $stable(sram_q))
      else $error("background write changed SRAM");
   chk_sec_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && sec_q && (jc_q == `IR_RD_SRAM || jc_q == `IR_RD_NV) |=> rd_q == '0)
      else $error("secured readback leaked data");
   chk_sec_sticky: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      sec_q && !(take && jc_q == `IR_ERASE) |=> sec_q)
      else $error("security cleared without erase");
   chk_live_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take && jc_q == `IR_LIVE_UPD |=> live_q && pin_off && eff_mode == '0)
      else $error("live update pins not held");
   cov_powerup: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(st_q == C_IDLE));
   cov_refresh: cover property (@(posedge I_CLK) disable iff (!I_RST_N) take && jc_q == `IR_REFRESH);
   cov_sec_read: cover property (@(posedge I_CLK) disable iff (!I_RST_N) take && sec_q && jc_q == `IR_RD_NV);
   cov_live: cover property (@(posedge I_CLK) disable iff (!I_RST_N) live_q ##1 !live_q);
endmodule : cfg_engine

//--- tb/jtag_prog.sv
// Purpose: Test-port programmer model that drives the configuration engine
// Assumes: The test clock runs only during test-port resets, scans and idle runs
// Notes:   TDI rests high, as if pulled up, between scans
`timescale 1ns/1ns
module jtag_prog (
   // Test port
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo
);
   // ********************
   // Scan sequences
   // ********************
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // Change after the falling edge, sample TDO at the rising edge
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #62;
      tdo = i_tdo;
      o_tck = 1'b1;
      #63;
      o_tck = 1'b0;
   endtask : step
   task automatic reset_tap();
      logic t;
      repeat (5) step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
   endtask : reset_tap
   task automatic idle(input int n);
      logic t;
      repeat (n) step(1'b0, 1'b1, t);
   endtask : idle
   // From idle to idle, LSB first
   task automatic ir_scan(input logic [3:0] code, output logic [3:0] q);
      logic t;
      step(1'b1, 1'b1, t);
      step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
      step(1'b0, 1'b1, t);
      for (int i = 0; i < 4; i++) step(i == 3, code[i], q[i]);
      step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
   endtask : ir_scan
   task automatic dr_scan(input logic [31:0] d, output logic [31:0] q);
      logic t;
      step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
      step(1'b0, 1'b1, t);
      for (int i = 0; i < 32; i++) step(i == 31, d[i], q[i]);
      step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
   endtask : dr_scan
endmodule : jtag_prog

//--- tb/cfg_engine_tb.sv
// Purpose: Self-checking bench for the configuration engine
// Assumes: Fixed idle runs after each command outlast the core's work
// Notes:   Pin modes repeat hold, low, high, tristate every four pins
`timescale 1ns/1ns
`include "cfg_regs.svh"
module cfg_engine_tb
   import cfg_pkg::*;
;
   localparam int NPIN = 8;
   localparam int WORDS = 16;
   logic clk, rst_n, tck, tms, tdi, tdo, user_en, secure, live, live_bad;
   logic [NPIN-1:0] user_o, user_oe, pio_o, pio_oe;
   logic [WORDS*`DR_W-1:0] sram, nv_exp;
   logic [31:0] cap;
   logic [3:0] ir_cap;
   logic tdo_pin, tdo_oe;
   int miscompares, n_tests;
   // ********************
   // Harness
   // ********************
   cfg_engine #(.NPIN(NPIN), .WORDS(WORDS)) u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_TCK(tck), .I_TMS(tms),
      .I_TDI(tdi), .O_TDO(tdo_pin), .O_TDO_OE(tdo_oe), .I_USER_O(user_o), .I_USER_OE(user_oe), .O_USER_EN(user_en),
      .O_SRAM_CFG(sram), .O_SECURE(secure), .O_PIO_O(pio_o), .O_PIO_OE(pio_oe));
   jtag_prog u_prog (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
   // A released TDO reads as its pull-up, so a late enable corrupts the captured bits
   assign tdo = tdo_oe ? tdo_pin : 1'b1;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Held pins must never drop during a live update
   always @(posedge clk) if (live && (pio_o !== 8'h5A || pio_oe !== 8'hFF)) live_bad <= 1'b1;
   function automatic logic [31:0] word(input int i);
      return 32'h9E37_79B9 * (i + 1);
   endfunction : word
   task automatic chk(input string w, input logic [511:0] e, input logic [511:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", w, e, g);
      end
   endtask : chk
   task automatic cmd(input logic [3:0] c, input logic [31:0] d);
      u_prog.ir_scan(c, ir_cap);
      chk("ir capture", `IR_CAPT, ir_cap);
      u_prog.dr_scan(d, cap);
      u_prog.idle(6);
      chk("tdo_oe idle", 0, tdo_oe);
      if (c != `IR_RD_NV && c != `IR_RD_SRAM) chk("busy", 0, cap[0]);
   endtask : cmd
   // Second scan under a read code captures the word issued by the first
   task automatic rd(input logic [3:0] c, input int a, input logic [31:0] e);
      cmd(`IR_ADDR, a);
      cmd(c, 32'h0);
      cmd(c, 32'h0);
      chk("read word", e, cap);
   endtask : rd
   task report_and_stop;
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   // ********************
   // Scenarios
   // ********************
   task automatic power_up();
      @(posedge clk);
      #1 chk("user_en load", 0, user_en);
      @(posedge clk) user_o <= 8'hA5;
      user_oe <= 8'hFF;
      repeat (WORDS + 8) @(posedge clk);
      #1 chk("user_en", 1, user_en);
      chk("sram", 0, sram);
      chk("secure", 0, secure);
      chk("pio_o", 8'hA5, pio_o);
   endtask : power_up
   task automatic bg_write();
      u_prog.reset_tap();
      cmd(`IR_ADDR, 0);
      for (int i = 0; i < WORDS; i++) begin
         cmd(`IR_NV_BG, word(i));
         nv_exp[32*i +: 32] = word(i);
         chk("user_en bg", 1, user_en);
      end
      chk("pio_oe bg", 8'hFF, pio_oe);
      chk("sram bg", 0, sram);
      rd(`IR_RD_NV, 3, word(3));
      cmd(`IR_REFRESH, 0);
      chk("sram refresh", nv_exp, sram);
   endtask : bg_write
   task automatic offline();
      cmd(`IR_PIN_SET, {16'h0000, {2{PM_TRI, PM_HIGH, PM_LOW, PM_HOLD}}});
      cmd(`IR_ADDR, 0);
      cmd(`IR_NV_OFF, 32'hFFFF_0000);
      chk("user_en off", 0, user_en);
      @(posedge clk) user_o <= 8'h5A;
      repeat (3) @(posedge clk);
      // Hold pins keep A5 although the user now drives 5A
      #1 chk("pio_oe off", 8'h77, pio_oe);
      chk("pio_o off", 8'h45, pio_o & 8'h77);
      cmd(`IR_ADDR, 1);
      cmd(`IR_SRAM_WR, 32'hABCD_1234);
      chk("sram word1", 32'hABCD_1234, sram[63:32]);
      cmd(`IR_EXIT, 0);
      repeat (3) @(posedge clk);
      #1 chk("user_en exit", 1, user_en);
      chk("pio_o exit", 8'h5A, pio_o);
   endtask : offline
   task automatic live_update();
      live = 1'b1;
      cmd(`IR_LIVE_UPD, 0);
      live = 1'b0;
      chk("live pins", 0, live_bad);
      chk("sram live0", 32'hFFFF_0000, sram[31:0]);
      chk("sram live1", word(1), sram[63:32]);
      chk("user_en live", 1, user_en);
      rd(`IR_RD_SRAM, 0, 32'hFFFF_0000);
   endtask : live_update
   task automatic security();
      cmd(`IR_SECURE, 0);
      chk("secure set", 1, secure);
      rd(`IR_RD_NV, 0, 32'h0);
      rd(`IR_RD_SRAM, 0, 32'h0);
      cmd(`IR_REFRESH, 0);
      cmd(`IR_EXIT, 0);
      chk("secure kept", 1, secure);
      cmd(`IR_ERASE, 0);
      chk("secure erase", 0, secure);
      chk("sram erase", 0, sram);
   endtask : security
   initial begin
      rst_n = 1'b0;
      user_o = 8'h00;
      user_oe = 8'h00;
      live = 1'b0;
      live_bad = 1'b0;
      miscompares = 0;
      n_tests = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      power_up();
      bg_write();
      offline();
      live_update();
      security();
      report_and_stop();
   end
   // A hang counts as a mismatch
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
endmodule : cfg_engine_tb
